// [common/ibu_pkg.sv]
// Package for the instruction breakpoint unit: offsets, fields, resets.
// Assumes a 32-bit byte-addressed debug access port in the clock domain.
//
// Functional notes
// - Only instruction fetches from the Code region are compared; data never matches.
// - Comparator enables count only while the global enable is 1.
// - A halfword match on a 16-bit instruction raises a breakpoint while debug is on.
// - With debug off, a raised event is escalated to a fault instead.
// - Control at 0xe0002000, comparator x at 0xe0002008 plus 4x, both read-write.
// - Control bits [7:4] report the read-only comparator count.
// - Control bit 1 reads zero; writes with bit 1 zero are ignored.
// - Control bit 0 is the global enable, cleared at reset.
// - Comparator bits [31:30] select none, lower, upper or both halfwords.
// - Comparator bits [28:2] hold address bits; other address bits taken as zero.
// - Comparator bit 0 enables that comparator, cleared at reset.
// - Reference address and mode fields need no reset value.
// - Comparators above the count read as zero; writes to them are ignored.
// - Registers are reached through the debug access port.
package ibu_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [31:0] CTRL_ADDR     = 32'he0002000;
   localparam logic [31:0] COMP_BASE     = 32'he0002008;
   // ----------------------------------------
   // Fields
   // ----------------------------------------
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_KEY_BIT  = 1;
   localparam int          CTRL_NUM_LSB  = 4;
   localparam int          COMP_EN_BIT   = 0;
   localparam int          COMP_ADDR_LSB = 2;
   localparam int          COMP_ADDR_MSB = 28;
   localparam int          COMP_SEL_LSB  = 30;
   localparam logic [2:0]  CODE_REGION   = 3'h0;
   localparam logic        EN_RESET      = 1'h0;
   localparam logic [31:0] UNIMPL_READ   = 32'h00000000;
   // ----------------------------------------
   // Halfword select modes
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      SEL_NONE  = 2'b00,
      SEL_LOWER = 2'b01,
      SEL_UPPER = 2'b10,
      SEL_BOTH  = 2'b11
   } ibu_sel_t;
endpackage

// [logic/ibu_comparator.sv]
// One breakpoint address comparator against a fetched halfword address.
// Assumes the fetch address is a byte address of a halfword.
`timescale 1ns/10ps
`default_nettype none
module ibu_comparator
(
   // Comparator setting
   input  wire logic [31:0] comp_reg_in,
   // Fetch
   input  wire logic [31:0] fetch_addr_in,
   // Result
   output var  logic        hit_out
);
   logic [31:0]    ref_addr;
   ibu_pkg::ibu_sel_t sel;
   logic           word_eq;
   logic           half_ok;

   always_comb
   begin
      ref_addr = {3'h0,
                  comp_reg_in[ibu_pkg::COMP_ADDR_MSB:ibu_pkg::COMP_ADDR_LSB],
                  2'h0};
      sel      = ibu_pkg::ibu_sel_t'(comp_reg_in[31:ibu_pkg::COMP_SEL_LSB]);
      word_eq  = (fetch_addr_in[31:2] == ref_addr[31:2]);
      case (sel)
         ibu_pkg::SEL_LOWER: half_ok = ~fetch_addr_in[1];
         ibu_pkg::SEL_UPPER: half_ok = fetch_addr_in[1];
         ibu_pkg::SEL_BOTH:  half_ok = 1'b1;
         default:            half_ok = 1'b0;
      endcase
      hit_out = comp_reg_in[ibu_pkg::COMP_EN_BIT] & word_eq & half_ok;
   end
endmodule // ibu_comparator
`default_nettype wire

// [logic/ibu_top.sv]
// Instruction breakpoint unit: control, comparators, debug port registers.
// Assumes fetch and debug port signals are synchronous to ref_clk_in.
// Assumes single-cycle word accesses on the debug port, one per cycle.
// Register writes reach fetch matching from the following cycle.
`timescale 1ns/10ps
`default_nettype none
module ibu_top
#(
   parameter int NUM_COMP = 4
)
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Debug access port
   input  wire logic        dap_sel_in,
   input  wire logic        dap_write_in,
   input  wire logic [31:0] dap_addr_in,
   input  wire logic [31:0] dap_wdata_in,
   output var  logic [31:0] dap_rdata_out,
   output var  logic        dap_ready_out,
   // Instruction fetch
   input  wire logic        fetch_valid_in,
   input  wire logic        fetch_is_instr_in,
   input  wire logic [31:0] fetch_addr_in,
   // Debug state
   input  wire logic        debug_global_on_in,
   // Events
   output var  logic        bkpt_event_out,
   output var  logic        escalated_fault_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed
   {
      logic                      glob_en;
      logic [NUM_COMP-1:0][31:0] comp;
      logic [31:0]               rdata;
      logic                      ready;
      logic                      bkpt;
      logic                      fault;
   } ibu_state_t;

   ibu_state_t                st_q;
   ibu_state_t                st_d;
   logic [NUM_COMP-1:0]       hit;
   logic [NUM_COMP-1:0]       armed;
   logic [NUM_COMP-1:0]       comp_sel;
   logic [NUM_COMP-1:0]       slot_wr;
   logic [NUM_COMP-1:0][31:0] slot_rd;
   logic                      ctrl_sel;
   logic                      fetch_ok;

   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   // Count field is four bits wide: at most 15 comparators can be reported
   localparam int         COUNT_W   = 4;
   localparam logic [3:0] COUNT_VAL = 4'(NUM_COMP);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Comparator slot of a bus address, -1 when below the bank or unaligned
   function automatic int comp_index(input logic [31:0] a);
      logic [31:0] off;
      off = a - ibu_pkg::COMP_BASE;
      if (a[1:0] != 2'h0 || a < ibu_pkg::COMP_BASE)
      begin
         return -1;
      end
      return int'(off[31:2]);
   endfunction

   // Key and reserved bits read zero
   function automatic logic [31:0] ctrl_word(input logic en);
      logic [31:0] w;
      w = 32'h00000000;
      w[ibu_pkg::CTRL_NUM_LSB+:COUNT_W] = COUNT_VAL;
      w[ibu_pkg::CTRL_EN_BIT]           = en;
      return w;
   endfunction

   // Reserved comparator bits are dropped on write, so they read zero
   function automatic logic [31:0] comp_word(input logic [31:0] w);
      logic [31:0] v;
      v = w;
      v[ibu_pkg::COMP_SEL_LSB-1]  = 1'b0;
      v[ibu_pkg::COMP_ADDR_LSB-1] = 1'b0;
      return v;
   endfunction

   // Only instruction reads from the Code region take part
   function automatic logic code_fetch
   (
      input logic        v,
      input logic        i,
      input logic [31:0] a
   );
      return v & i & (a[31:29] == ibu_pkg::CODE_REGION);
   endfunction

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign ctrl_sel = dap_sel_in &
                     (dap_addr_in == ibu_pkg::CTRL_ADDR);

   // ----------------------------------------
   // Fetch qualification
   // ----------------------------------------
   assign fetch_ok = code_fetch(fetch_valid_in, fetch_is_instr_in,
                                fetch_addr_in);

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_COMP; g++)
      begin : g_cmp
         // Slots at or above NUM_COMP never decode
         assign comp_sel[g] = dap_sel_in &
                              (comp_index(dap_addr_in) == g);
         assign slot_wr[g]  = comp_sel[g] & dap_write_in;
         assign slot_rd[g]  = (comp_sel[g] & ~dap_write_in) ?
                              st_q.comp[g] : 32'h00000000;
         // Own enable counts only under the global enable
         assign armed[g]    = st_q.glob_en & hit[g];
         ibu_comparator u_cmp
         (
            .comp_reg_in   (st_q.comp[g]),
            .fetch_addr_in (fetch_addr_in),
            .hit_out       (hit[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      logic fire;
      fire       = 1'b0;
      st_d       = st_q;
      // Every access is answered one cycle later, with no wait states
      st_d.ready = dap_sel_in;
      st_d.rdata = ibu_pkg::UNIMPL_READ;
      if (ctrl_sel)
      begin
         if (dap_write_in && dap_wdata_in[ibu_pkg::CTRL_KEY_BIT])
         begin
            st_d.glob_en = dap_wdata_in[ibu_pkg::CTRL_EN_BIT];
         end
         else if (!dap_write_in)
         begin
            st_d.rdata = ctrl_word(st_q.glob_en);
         end
      end
      else if (|comp_sel)
      begin
         for (int i = 0; i < NUM_COMP; i++)
         begin
            if (slot_wr[i])
            begin
               st_d.comp[i] = comp_word(dap_wdata_in);
            end
            st_d.rdata = st_d.rdata | slot_rd[i];
         end
      end
      // Unmapped and unimplemented slots read zero, writes dropped
      // One event per fetch, however many comparators match
      if (fetch_ok)
      begin
         fire = |armed;
      end
      // Event raised also with debug off, then escalated instead
      st_d.bkpt  = fire & debug_global_on_in;
      st_d.fault = fire & ~debug_global_on_in;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         // Address and mode fields keep no reset value
         st_q.glob_en <= ibu_pkg::EN_RESET;
         for (int i = 0; i < NUM_COMP; i++)
         begin
            st_q.comp[i][ibu_pkg::COMP_EN_BIT] <=
               ibu_pkg::EN_RESET;
         end
         st_q.rdata <= 32'h00000000;
         st_q.ready <= 1'b0;
         st_q.bkpt  <= 1'b0;
         st_q.fault <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Straight from the registered state, no logic after the flip-flops
   always_comb
   begin
      dap_rdata_out       = st_q.rdata;
      dap_ready_out       = st_q.ready;
      bkpt_event_out      = st_q.bkpt;
      escalated_fault_out = st_q.fault;
   end
endmodule // ibu_top
`default_nettype wire

// [dv/ibu_fetch_model.sv]
// Processor fetch side: one fetch while go_in is high.
// Idle lines show inverted values so stale data never passes for a fetch.
`timescale 1ns/10ps
`default_nettype none
module ibu_fetch_model
(
   input  wire logic        go_in,
   input  wire logic        instr_in,
   input  wire logic [31:0] addr_in,
   output var  logic        valid_out,
   output var  logic        instr_out,
   output var  logic [31:0] addr_out
);
   assign valid_out = go_in;
   assign instr_out = go_in ? instr_in : ~instr_in;
   assign addr_out  = go_in ? addr_in : ~addr_in;
endmodule // ibu_fetch_model
`default_nettype wire

// [dv/ibu_properties.sv]
// Port timing checker for the instruction breakpoint unit.
// Sees only the top ports; bound into every ibu_top instance.
`timescale 1ns/10ps
`default_nettype none
module ibu_properties
#(
   parameter int NUM_COMP = 4
)
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Debug access port
   input  wire logic        dap_sel_in,
   input  wire logic        dap_write_in,
   input  wire logic [31:0] dap_addr_in,
   input  wire logic [31:0] dap_rdata_out,
   input  wire logic        dap_ready_out,
   // Instruction fetch
   input  wire logic        fetch_valid_in,
   input  wire logic        fetch_is_instr_in,
   input  wire logic [31:0] fetch_addr_in,
   // Debug state and events
   input  wire logic        debug_global_on_in,
   input  wire logic        bkpt_event_out,
   input  wire logic        escalated_fault_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_ctl;
      dap_sel_in && !dap_write_in && dap_addr_in == ibu_pkg::CTRL_ADDR;
   endsequence
   property p_rdy; dap_sel_in |=> dap_ready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("late ready");
   property p_stray; !dap_sel_in |=> !dap_ready_out; endproperty
   a_stray: assert property (p_stray) else $error("stray");
   property p_idle; !dap_ready_out |-> dap_rdata_out == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("idle data");
   property p_wr0;
      dap_sel_in && dap_write_in |=> dap_rdata_out == 32'h0;
   endproperty
   a_wr0: assert property (p_wr0) else $error("write data");
   property p_ctl;
      s_ctl |=> dap_rdata_out[7:4] == NUM_COMP[3:0] && !dap_rdata_out[1];
   endproperty
   a_ctl: assert property (p_ctl) else $error("control");
   property p_dbg; bkpt_event_out |-> $past(debug_global_on_in); endproperty
   a_dbg: assert property (p_dbg) else $error("event");
   property p_flt;
      escalated_fault_out |-> !$past(debug_global_on_in);
   endproperty
   a_flt: assert property (p_flt) else $error("fault");
   property p_one; !(bkpt_event_out && escalated_fault_out); endproperty
   a_one: assert property (p_one) else $error("both");
   // No fetch, a data access or a fetch outside the Code region
   sequence s_nofetch;
      !fetch_valid_in || !fetch_is_instr_in ||
      fetch_addr_in[31:29] != ibu_pkg::CODE_REGION;
   endsequence
   sequence s_quiet;
      !bkpt_event_out && !escalated_fault_out;
   endsequence
   property p_nofetch; s_nofetch |=> s_quiet; endproperty
   a_nofetch: assert property (p_nofetch) else $error("no fetch");
endmodule // ibu_properties
bind ibu_top ibu_properties #(.NUM_COMP(NUM_COMP)) u_props (.ref_clk_in,
   .rst_in, .dap_sel_in, .dap_write_in, .dap_addr_in, .dap_rdata_out,
   .dap_ready_out, .fetch_valid_in, .fetch_is_instr_in, .fetch_addr_in,
   .debug_global_on_in, .bkpt_event_out, .escalated_fault_out);
`default_nettype wire

// [dv/ibu_tb.sv]
// Bench: control key, halfword modes, refused fetches, escalation, reset.
// Assumes one ibu_top with four comparators on a single 8 ns clock.
`timescale 1ns/10ps
`default_nettype none
module ibu_tb;
   localparam int          NC = 4;
   localparam logic [31:0] N  = NC << 4;
   localparam logic [31:0] C  = ibu_pkg::CTRL_ADDR;
   localparam logic [31:0] K  = ibu_pkg::COMP_BASE + 32'h4;
   localparam logic [31:0] A  = 32'h00001230;
   localparam logic [31:0] U  = ibu_pkg::COMP_BASE + 32'(NC * 4);
   logic        clk = 1'h0, rst = 1'h1, sel = 1'h0, we = 1'h0;
   logic        go = 1'h0, fi = 1'h0, dbg = 1'h1, fv, fs, bk, ef, rdy;
   logic [31:0] adr = 32'h0, wd = 32'h0, fa = 32'h0, fad, rd;
   int          n_errors = 0, check_count = 0;
   always #4 clk = ~clk;
   ibu_top #(.NUM_COMP(NC)) uut (.ref_clk_in(clk), .rst_in(rst),
      .dap_sel_in(sel), .dap_write_in(we), .dap_addr_in(adr),
      .dap_wdata_in(wd), .dap_rdata_out(rd), .dap_ready_out(rdy),
      .fetch_valid_in(fv), .fetch_is_instr_in(fs), .fetch_addr_in(fad),
      .debug_global_on_in(dbg), .bkpt_event_out(bk),
      .escalated_fault_out(ef));
   ibu_fetch_model fm (.go_in(go), .instr_in(fi), .addr_in(fa),
      .valid_out(fv), .instr_out(fs), .addr_out(fad));
   task automatic conclude;
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t %h %h", $time, got, exp);
      end
   endtask
   // A read compares its word with d
   task automatic acc(input logic w, input logic [31:0] a, d);
      @(posedge clk) {sel, we, adr, wd} <= {1'h1, w, a, d};
      @(posedge clk) sel <= 1'h0;
      @(negedge clk) chk({31'h0, rdy}, 32'h1);
      if (!w) chk(rd, d);
   endtask
   task automatic fet(input logic [31:0] a, input logic i, input logic [1:0] e);
      @(posedge clk) {go, fi, fa} <= {1'h1, i, a};
      @(posedge clk) go <= 1'h0;
      @(negedge clk) chk({30'h0, bk, ef}, {30'h0, e});
   endtask
   task automatic t_regs;
      acc(1'h0, C, N);
      acc(1'h1, C, 32'h1);
      acc(1'h0, C, N);
      acc(1'h1, C, 32'h3);
      acc(1'h0, C, N | 32'h1);
      acc(1'h1, U, 32'h0);
      acc(1'h0, U, ibu_pkg::UNIMPL_READ);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         acc(1'h1, K, {m[1:0], 30'h1} | A);
         fet(A, 1'h1, {m[0], 1'h0});
         fet(A + 32'h2, 1'h1, {m[1], 1'h0});
      end
      acc(1'h1, K, 32'he0000003 | A);
      acc(1'h0, K, 32'hc0000001 | A);
   endtask
   task automatic t_refuse;
      fet(A, 1'h0, 2'h0);
      fet(A | 32'h20000000, 1'h1, 2'h0);
      @(posedge clk) dbg <= 1'h0;
      fet(A, 1'h1, 2'h1);
      acc(1'h1, C, 32'h2);
      fet(A, 1'h1, 2'h0);
      acc(1'h1, C, 32'h3);
      acc(1'h1, K, 32'hc0000000 | A);
      fet(A, 1'h1, 2'h0);
   endtask
   // Mid-run reset clears both enables, keeps the count readable
   task automatic t_reset;
      acc(1'h1, K, 32'hc0000001 | A);
      @(posedge clk) rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      acc(1'h0, C, N);
      acc(1'h1, C, 32'h3);
      fet(A, 1'h1, 2'h0);
      acc(1'h1, K, 32'hc0000001 | A);
      fet(A, 1'h1, 2'h1);
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      t_regs;
      t_modes;
      t_refuse;
      t_reset;
      conclude;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      n_errors++;
      conclude;
   end
endmodule // ibu_tb
`default_nettype wire
